// >>> hw/ucs_pkg.sv
package ucs_pkg;

    localparam int ADR_W = 12;
    localparam int DAT_W = 32;
    localparam int KEY_WORDS = 4;
    localparam int KEY_WORD_BITS = 32;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_DEBUG_LOCK = 12'h000;
    localparam logic [11:0] OFS_HV_REG_SEL = 12'h010;
    localparam logic [11:0] OFS_XTAL_DEBOUNCE = 12'h014;
    localparam logic [11:0] OFS_SEC_DEBUG_LOCK = 12'h01c;
    localparam logic [11:0] OFS_ERASE_LOCK = 12'h020;
    localparam logic [11:0] OFS_DEBUG_TARGET = 12'h024;
    localparam logic [11:0] OFS_NFC_PIN_FUNC = 12'h028;
    localparam logic [11:0] OFS_OTP = 12'h100;
    localparam logic [11:0] OFS_SLOT_DEST = 12'h400;
    localparam logic [11:0] OFS_SLOT_PERM = 12'h404;
    localparam logic [11:0] OFS_KEY_VALUE = 12'h800;
    localparam logic [11:0] SLOT_STRIDE = 12'h008;
    localparam logic [11:0] KEY_STRIDE = 12'h010;
    localparam logic [11:0] WORD_STRIDE = 12'h004;
    localparam logic [11:0] KEY_AREA_BASE = 12'h100;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and field codes
    localparam logic [31:0] RST_DEBUG_LOCK = 32'h0000_0000;
    localparam logic [31:0] RST_SEC_DEBUG_LOCK = 32'h0000_0000;
    localparam logic [31:0] RST_ERASE_LOCK = 32'h0000_0000;
    localparam logic [31:0] RST_ERASED = 32'hffff_ffff;
    localparam logic [31:0] DEBUG_UNPROTECTED = 32'h50fa_50fa;
    localparam logic [31:0] ERASE_UNPROTECTED = 32'hffff_ffff;
    localparam logic [15:0] PERM_HALF_FREE = 16'hffff;
    localparam int NFC_ANTENNA_BIT = 0;

    typedef enum logic [3:0] {
        RGN_NONE, RGN_DBG, RGN_HV, RGN_XTAL, RGN_SEC, RGN_ERASE,
        RGN_TGT, RGN_NFC, RGN_OTP, RGN_DEST, RGN_PERM, RGN_KEY
    } ucs_region_type;

    typedef enum logic [1:0] {
        PUSH_IDLE = 2'b01,
        PUSH_SEND = 2'b10
    } ucs_push_state_type;

endpackage

// >>> hw/ucs_key_if.sv
`timescale 1ns/1ps
interface ucs_key_if #(parameter int SLOT_W = 2);
    logic [SLOT_W-1:0] slot_sel;
    logic [1:0] word_sel;
    logic [31:0] dest;
    logic [31:0] value;
    logic slot_ok;

    modport store (input slot_sel, input word_sel, output dest, output value, output slot_ok);
    modport pusher (output slot_sel, output word_sel, input dest, input value, input slot_ok);
endinterface

// >>> hw/ucs_key_push.sv
`timescale 1ns/1ps
module ucs_key_push
    import ucs_pkg::*;
#(
    parameter int SLOT_W = 2
) (
    input wire logic ref_clk,
    input wire logic reset,
    ucs_key_if.pusher key,
    input wire logic push_req,
    input wire logic [SLOT_W-1:0] push_slot,
    output logic push_busy,
    output logic push_done,
    output logic push_err,
    output logic key_wr_valid,
    input wire logic key_wr_ready,
    output logic [31:0] key_wr_addr,
    output logic [31:0] key_wr_data
);

    ucs_push_state_type state_ff;
    logic [SLOT_W-1:0] slot_ff;
    logic [1:0] word_ff;
    logic [1:0] nxt_word;
    logic idle;
    logic step;

    assign idle = (state_ff == PUSH_IDLE);
    assign step = (state_ff == PUSH_SEND) && key_wr_ready;
    assign nxt_word = idle ? 2'h0 : word_ff + 2'h1;
    assign key.slot_sel = idle ? push_slot : slot_ff;
    assign key.word_sel = nxt_word;
    assign push_busy = !idle;
    assign key_wr_valid = (state_ff == PUSH_SEND);

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_ff <= PUSH_IDLE;
            slot_ff <= '0;
            word_ff <= 2'h0;
        end else begin
            unique case (state_ff)
                PUSH_IDLE: begin
                    if (push_req && key.slot_ok) begin
                        state_ff <= PUSH_SEND;
                        slot_ff <= push_slot;
                        word_ff <= 2'h0;
                    end
                end
                PUSH_SEND: begin
                    if (step) begin
                        word_ff <= nxt_word;
                        if (word_ff == 2'(KEY_WORDS - 1)) begin
                            state_ff <= PUSH_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Each word lands one stride above the last, starting at the slot destination
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            key_wr_addr <= '0;
            key_wr_data <= '0;
        end else if ((idle && push_req && key.slot_ok) || (step && word_ff != 2'h3)) begin
            key_wr_addr <= key.dest + {28'h0, nxt_word, 2'h0};
            key_wr_data <= key.value;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            push_done <= 1'b0;
            push_err <= 1'b0;
        end else begin
            push_done <= step && (word_ff == 2'(KEY_WORDS - 1));
            push_err <= idle && push_req && !key.slot_ok;
        end
    end

endmodule

// >>> hw/ucs_top.sv
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
// Operation
// - Each slot stores a destination address; pushed key words go there.
// - Each permission half takes a write only while it still reads 0xffff.
// - Value word o of a slot carries key bits 32*o up to 32*o+31.
// - NFC pin register picks antenna use or plain general-purpose pins.
// - Space from 0x100 up belongs to key management, not plain settings.
// - Only the application processor reaches the store; network side is shut out.
module ucs_top
    import ucs_pkg::*;
#(
    parameter int NUM_OTP = 8,
    parameter int NUM_SLOTS = 4,
    parameter int SLOT_W = 2
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DAT_W-1:0] wb_dat_i,
    output logic [DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic net_core_access,
    input wire logic push_req,
    input wire logic [SLOT_W-1:0] push_slot,
    output logic push_busy,
    output logic push_done,
    output logic push_err,
    output logic key_wr_valid,
    input wire logic key_wr_ready,
    output logic [31:0] key_wr_addr,
    output logic [31:0] key_wr_data,
    output logic debug_lock_active,
    output logic secure_debug_lock_active,
    output logic erase_lock_active,
    output logic nfc_pins_as_antenna,
    output logic [31:0] hv_regulator_setting,
    output logic [31:0] crystal_debounce_setting,
    output logic [31:0] debug_target_setting
);

    logic [31:0] dbg_lock_ff;
    logic [31:0] sec_lock_ff;
    logic [31:0] erase_lock_ff;
    logic [31:0] hv_sel_ff;
    logic [31:0] xtal_ff;
    logic [31:0] tgt_ff;
    logic [31:0] nfc_ff;
    logic [31:0] otp_ff [NUM_OTP];
    logic [31:0] dest_ff [NUM_SLOTS];
    logic [31:0] perm_ff [NUM_SLOTS];
    logic [31:0] key_ff [NUM_SLOTS*KEY_WORDS];
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic req;
    logic wr_en;
    ucs_region_type rgn;
    logic [9:0] idx;
    logic [31:0] wmerge;

    ucs_key_if #(.SLOT_W(SLOT_W)) key_bus ();

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode, shared by write and read paths
    function automatic ucs_region_type region_of(input logic [11:0] a);
        region_of = RGN_NONE;
        if (a == OFS_DEBUG_LOCK) region_of = RGN_DBG;
        else if (a == OFS_HV_REG_SEL) region_of = RGN_HV;
        else if (a == OFS_XTAL_DEBOUNCE) region_of = RGN_XTAL;
        else if (a == OFS_SEC_DEBUG_LOCK) region_of = RGN_SEC;
        else if (a == OFS_ERASE_LOCK) region_of = RGN_ERASE;
        else if (a == OFS_DEBUG_TARGET) region_of = RGN_TGT;
        else if (a == OFS_NFC_PIN_FUNC) region_of = RGN_NFC;
        else if (a >= OFS_OTP && a < OFS_OTP + 12'(NUM_OTP * 4)) region_of = RGN_OTP;
        else if (a >= OFS_SLOT_DEST && a < OFS_SLOT_DEST + 12'(NUM_SLOTS * 8)) begin
            region_of = a[2] ? RGN_PERM : RGN_DEST;
        end else if (a >= OFS_KEY_VALUE && a < OFS_KEY_VALUE + 12'(NUM_SLOTS * 16)) begin
            region_of = RGN_KEY;
        end
    endfunction

    function automatic logic [9:0] index_of(input logic [11:0] a, input ucs_region_type r);
        logic [11:0] d;
        d = 12'h000;
        if (r == RGN_OTP) d = (a - OFS_OTP) >> 2;
        else if (r == RGN_DEST || r == RGN_PERM) d = (a - OFS_SLOT_DEST) >> 3;
        else if (r == RGN_KEY) d = (a - OFS_KEY_VALUE) >> 2;
        index_of = d[9:0];
    endfunction

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            lane_merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
    endfunction

    // Word-aligned only; byte offsets within a word are ignored
    assign rgn = region_of({wb_adr_i[11:2], 2'b00});
    assign idx = index_of({wb_adr_i[11:2], 2'b00}, rgn);
    // Network side requests still get an ack so that bus never hangs
    assign req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_en = req && wb_we_i && !net_core_access;
    assign wmerge = lane_merge(32'hffff_ffff, wb_dat_i, wb_sel_i);

    ////////////////////////////////////////////////////////////////////////////////
    // Lock words: writes can only clear bits, as in flash
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dbg_lock_ff <= RST_DEBUG_LOCK;
            sec_lock_ff <= RST_SEC_DEBUG_LOCK;
            erase_lock_ff <= RST_ERASE_LOCK;
        end else if (wr_en) begin
            if (rgn == RGN_DBG) dbg_lock_ff <= dbg_lock_ff & wmerge;
            if (rgn == RGN_SEC) sec_lock_ff <= sec_lock_ff & wmerge;
            if (rgn == RGN_ERASE) erase_lock_ff <= erase_lock_ff & wmerge;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hv_sel_ff <= RST_ERASED;
            xtal_ff <= RST_ERASED;
            tgt_ff <= RST_ERASED;
            nfc_ff <= RST_ERASED;
        end else if (wr_en) begin
            if (rgn == RGN_HV) hv_sel_ff <= hv_sel_ff & wmerge;
            if (rgn == RGN_XTAL) xtal_ff <= xtal_ff & wmerge;
            if (rgn == RGN_TGT) tgt_ff <= tgt_ff & wmerge;
            if (rgn == RGN_NFC) nfc_ff <= nfc_ff & wmerge;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Key management area
    generate
        for (genvar i = 0; i < NUM_OTP; i++) begin : g_otp
            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    otp_ff[i] <= RST_ERASED;
                end else if (wr_en && rgn == RGN_OTP && idx == 10'(i)) begin
                    otp_ff[i] <= otp_ff[i] & wmerge;
                end
            end
        end
        for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    dest_ff[s] <= RST_ERASED;
                    perm_ff[s] <= RST_ERASED;
                end else if (wr_en && idx == 10'(s)) begin
                    if (rgn == RGN_DEST) dest_ff[s] <= dest_ff[s] & wmerge;
                    // A half is sealed once any of its bits has been cleared
                    if (rgn == RGN_PERM && perm_ff[s][15:0] == PERM_HALF_FREE) begin
                        perm_ff[s][15:0] <= wmerge[15:0];
                    end
                    if (rgn == RGN_PERM && perm_ff[s][31:16] == PERM_HALF_FREE) begin
                        perm_ff[s][31:16] <= wmerge[31:16];
                    end
                end
            end
        end
        for (genvar k = 0; k < NUM_SLOTS * KEY_WORDS; k++) begin : g_key
            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    key_ff[k] <= RST_ERASED;
                end else if (wr_en && rgn == RGN_KEY && idx == 10'(k)) begin
                    key_ff[k] <= key_ff[k] & wmerge;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Slot lookup for the push engine
    assign key_bus.slot_ok = int'(key_bus.slot_sel) < NUM_SLOTS;
    assign key_bus.dest = key_bus.slot_ok ? dest_ff[key_bus.slot_sel] : 32'h0;
    assign key_bus.value = key_bus.slot_ok ?
        key_ff[{key_bus.slot_sel, key_bus.word_sel}] : 32'h0;

    ucs_key_push #(.SLOT_W(SLOT_W)) u_push (
        .ref_clk(ref_clk),
        .reset(reset),
        .key(key_bus.pusher),
        .push_req(push_req),
        .push_slot(push_slot),
        .push_busy(push_busy),
        .push_done(push_done),
        .push_err(push_err),
        .key_wr_valid(key_wr_valid),
        .key_wr_ready(key_wr_ready),
        .key_wr_addr(key_wr_addr),
        .key_wr_data(key_wr_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait state, unmapped reads give zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ack_ff <= req;
            rdata_ff <= 32'h0;
            if (req && !wb_we_i && !net_core_access) begin
                unique case (rgn)
                    RGN_DBG: rdata_ff <= dbg_lock_ff;
                    RGN_HV: rdata_ff <= hv_sel_ff;
                    RGN_XTAL: rdata_ff <= xtal_ff;
                    RGN_SEC: rdata_ff <= sec_lock_ff;
                    RGN_ERASE: rdata_ff <= erase_lock_ff;
                    RGN_TGT: rdata_ff <= tgt_ff;
                    RGN_NFC: rdata_ff <= nfc_ff;
                    RGN_OTP: rdata_ff <= otp_ff[idx[$clog2(NUM_OTP)-1:0]];
                    RGN_DEST: rdata_ff <= dest_ff[idx[SLOT_W-1:0]];
                    RGN_PERM: rdata_ff <= perm_ff[idx[SLOT_W-1:0]];
                    // Key words stay secret; only the push engine reads them
                    RGN_KEY: rdata_ff <= 32'h0;
                    default: rdata_ff <= 32'h0;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Settings seen by the rest of the chip
    assign debug_lock_active = (dbg_lock_ff != DEBUG_UNPROTECTED);
    assign secure_debug_lock_active = (sec_lock_ff != DEBUG_UNPROTECTED);
    assign erase_lock_active = (erase_lock_ff != ERASE_UNPROTECTED);
    assign nfc_pins_as_antenna = nfc_ff[NFC_ANTENNA_BIT];
    assign hv_regulator_setting = hv_sel_ff;
    assign crystal_debounce_setting = xtal_ff;
    assign debug_target_setting = tgt_ff;

endmodule

// >>> sim/ucs_top_chk.sv
`timescale 1ns/1ps
module ucs_top_chk
    import ucs_pkg::*;
#(
    parameter int NUM_SLOTS = 4,
    parameter int SLOT_W = 2
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DAT_W-1:0] wb_dat_i,
    input wire logic [DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic net_core_access,
    input wire logic push_req,
    input wire logic [SLOT_W-1:0] push_slot,
    input wire logic push_busy,
    input wire logic push_err,
    input wire logic key_wr_valid,
    input wire logic key_wr_ready,
    input wire logic [31:0] key_wr_addr,
    input wire logic [31:0] key_wr_data,
    input wire logic debug_lock_active,
    input wire logic nfc_pins_as_antenna
);
    logic req;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    a_ack_follows: assert property (req |=> wb_ack_o) else $error("ack missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not zero");
    a_net_read_zero: assert property (
        req && !wb_we_i && net_core_access |=> wb_dat_o == 32'h0) else $error("net read leak");
    a_nfc_clear: assert property (
        req && wb_we_i && !net_core_access && wb_adr_i == OFS_NFC_PIN_FUNC && wb_sel_i[0]
        && !wb_dat_i[0] |=> !nfc_pins_as_antenna) else $error("nfc still antenna");
    // Lock resets protected and bits only clear, so it can never open
    a_debug_lock_holds: assert property (!$fell(debug_lock_active)) else $error("lock opened");
    a_push_start: assert property (
        push_req && !push_busy && push_slot < NUM_SLOTS |=> key_wr_valid) else $error("no push");
    a_valid_busy: assert property (key_wr_valid |-> push_busy)
        else $error("valid while idle");
    a_push_refuse: assert property (
        push_req && !push_busy && push_slot >= NUM_SLOTS |=> push_err && !key_wr_valid)
        else $error("bad slot pushed");
    a_word_hold: assert property (
        key_wr_valid && !key_wr_ready |=> key_wr_valid && $stable(key_wr_addr)
        && $stable(key_wr_data)) else $error("word not held");
    a_addr_step: assert property (
        key_wr_valid && key_wr_ready ##1 key_wr_valid |-> key_wr_addr == $past(key_wr_addr)
        + 32'h4) else $error("address step");
endmodule
bind ucs_top ucs_top_chk #(.NUM_SLOTS(NUM_SLOTS), .SLOT_W(SLOT_W)) chk (
    .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .net_core_access(net_core_access),
    .push_req(push_req), .push_slot(push_slot), .push_busy(push_busy), .push_err(push_err),
    .key_wr_valid(key_wr_valid), .key_wr_ready(key_wr_ready), .key_wr_addr(key_wr_addr),
    .key_wr_data(key_wr_data), .debug_lock_active(debug_lock_active),
    .nfc_pins_as_antenna(nfc_pins_as_antenna));

// >>> sim/ucs_key_sink.sv
`timescale 1ns/1ps
// Write-only key register of a peripheral; slow mode stalls every other cycle
module ucs_key_sink (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic key_wr_valid,
    output logic key_wr_ready,
    input wire logic [31:0] key_wr_addr,
    input wire logic [31:0] key_wr_data
);
    logic [31:0] got_addr [4];
    logic [31:0] got_data [4];
    logic [1:0] cnt_ff;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) key_wr_ready <= 1'b0;
        else key_wr_ready <= slow ? ~key_wr_ready : 1'b1;
    end
    // Index wraps, so each push of four words refills the same slots
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= 2'h0;
        end else if (key_wr_valid && key_wr_ready) begin
            got_addr[cnt_ff] <= key_wr_addr;
            got_data[cnt_ff] <= key_wr_data;
            cnt_ff <= cnt_ff + 2'h1;
        end
    end
endmodule

// >>> sim/user_config_key_slot_map_test.sv
`timescale 1ns/1ps
module user_config_key_slot_map_test
    import ucs_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic net_core_access = 1'b0;
    logic push_req = 1'b0;
    logic [1:0] push_slot = 2'h0;
    logic slow = 1'b1;
    logic [31:0] wb_dat_o, key_wr_addr, key_wr_data, q;
    logic wb_ack_o, push_busy, push_done, push_err, key_wr_valid, key_wr_ready;
    logic debug_lock_active, nfc_pins_as_antenna, sec_lock_act, erase_lock_act;
    logic [31:0] xtal_set, hv_set, tgt_set;
    int fail_count = 0;
    int cmp_count = 0;
    // Three slots so that slot index 3 exercises the refusal path
    ucs_top #(.NUM_OTP(8), .NUM_SLOTS(3), .SLOT_W(2)) DUT (
        .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .net_core_access(net_core_access),
        .push_req(push_req), .push_slot(push_slot), .push_busy(push_busy),
        .push_done(push_done), .push_err(push_err), .key_wr_valid(key_wr_valid),
        .key_wr_ready(key_wr_ready), .key_wr_addr(key_wr_addr), .key_wr_data(key_wr_data),
        .debug_lock_active(debug_lock_active), .secure_debug_lock_active(sec_lock_act),
        .erase_lock_active(erase_lock_act), .nfc_pins_as_antenna(nfc_pins_as_antenna),
        .hv_regulator_setting(hv_set), .crystal_debounce_setting(xtal_set),
        .debug_target_setting(tgt_set));
    ucs_key_sink sink (.ref_clk(ref_clk), .reset(reset), .slow(slow),
        .key_wr_valid(key_wr_valid), .key_wr_ready(key_wr_ready),
        .key_wr_addr(key_wr_addr), .key_wr_data(key_wr_data));
    always #10 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until ack is sampled high, then released for a cycle
    task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d,
                       input logic net);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        net_core_access <= net;
        do begin @(posedge ref_clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        if (n >= 20) fail_count++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        net_core_access <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 1'b0);
        check(q, exp);
    endtask
    task automatic push(input logic [1:0] s, input logic err);
        int n;
        n = 0;
        @(posedge ref_clk);
        push_req <= 1'b1;
        push_slot <= s;
        @(posedge ref_clk);
        push_req <= 1'b0;
        do begin @(posedge ref_clk); n++; end
        while ((err ? push_err : push_done) !== 1'b1 && n < 40);
        if (n >= 40) fail_count++;
    endtask
    // Base differs per push so stale words from an earlier push cannot pass
    task automatic words(input logic [31:0] base);
        for (int o = 0; o < 4; o++) begin
            check(sink.got_addr[o], base + 32'(4 * o));
            check(sink.got_data[o], 32'hc0de_0000 | 32'(o));
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        rd(OFS_DEBUG_LOCK, RST_DEBUG_LOCK);
        wr(OFS_DEBUG_LOCK, DEBUG_UNPROTECTED);
        rd(OFS_DEBUG_LOCK, 32'h0);
        check({31'h0, debug_lock_active}, 32'h1);
        check({31'h0, sec_lock_act}, 32'h1);
        wr(OFS_ERASE_LOCK, ERASE_UNPROTECTED);
        check({31'h0, erase_lock_act}, 32'h1);
        wr(OFS_HV_REG_SEL, 32'h0000_0005);
        check(hv_set, 32'h0000_0005);
        wr(OFS_DEBUG_TARGET, 32'hffff_fff0);
        check(tgt_set, 32'hffff_fff0);
        rd(OFS_NFC_PIN_FUNC, RST_ERASED);
        wr(OFS_NFC_PIN_FUNC, 32'hffff_fffe);
        check({31'h0, nfc_pins_as_antenna}, 32'h0);
        $display("test settings done");
        bus(1'b1, OFS_XTAL_DEBOUNCE, 32'h0, 1'b1);
        rd(OFS_XTAL_DEBOUNCE, RST_ERASED);
        bus(1'b0, OFS_XTAL_DEBOUNCE, 32'h0, 1'b1);
        check(q, 32'h0);
        check(xtal_set, RST_ERASED);
        $display("test network side done");
        wr(OFS_OTP + 12'h4, 32'h1234_5678);
        rd(OFS_OTP + 12'h4, 32'h1234_5678);
        rd(12'h200, 32'h0);
        wr(OFS_SLOT_PERM, 32'hffff_1234);
        rd(OFS_SLOT_PERM, 32'hffff_1234);
        wr(OFS_SLOT_PERM, 32'h0000_0000);
        rd(OFS_SLOT_PERM, 32'h0000_1234);
        wr(OFS_SLOT_PERM, 32'hffff_ffff);
        rd(OFS_SLOT_PERM, 32'h0000_1234);
        $display("test upper area done");
        wr(OFS_SLOT_DEST + SLOT_STRIDE, 32'h4000_2000);
        for (int o = 0; o < 4; o++) wr(OFS_KEY_VALUE + KEY_STRIDE + 12'(4 * o),
                                        32'hc0de_0000 | 32'(o));
        rd(OFS_KEY_VALUE + KEY_STRIDE, 32'h0);
        push(2'd1, 1'b0);
        words(32'h4000_2000);
        push(2'd3, 1'b1);
        check({31'h0, key_wr_valid}, 32'h0);
        slow <= 1'b0;
        wr(OFS_SLOT_DEST + SLOT_STRIDE, 32'h4000_0000);
        push(2'd1, 1'b0);
        words(32'h4000_0000);
        $display("test key push done");
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        stop_test();
    end
endmodule
